/* File: bench/buffer_dma_copy_checksum_asserts.sv */
// Port assertions of the buffer DMA engine, bound onto its top module.
`timescale 1ns/1ns
module dma_port_checker (
	input wire        pclk,
	input wire        presetn,
	input wire        psel,
	input wire        penable,
	input wire        pwrite,
	input wire [7:0]  paddr,
	input wire [31:0] pwdata,
	input wire [31:0] prdata,
	input wire        pready,
	input wire        pslverr,
	input wire        mem_req,
	input wire        mem_we,
	input wire [14:0] mem_addr,
	input wire [15:0] mem_wdata,
	input wire [1:0]  mem_wstrb,
	input wire        mem_ack,
	input wire [15:0] mem_rdata,
	input wire        irq
);
	default clocking ck @(posedge pclk); endclocking
	default disable iff (!presetn);

	// ============================================================
	// Memory handshake: a cancel may drop a waiting request, so only a request that stays up is held.
	sequence s_wait;
		mem_req && !mem_ack;
	endsequence
	sequence s_taken;
		mem_req && mem_ack;
	endsequence
	a_req_held: assert property (s_wait ##1 mem_req |-> $stable({mem_we, mem_addr, mem_wdata, mem_wstrb}))
		else $error("memory request changed before acknowledge");
	a_req_release: assert property (s_taken |=> !mem_req)
		else $error("memory request not released after acknowledge");
	a_addr_legal: assert property (mem_req |-> mem_addr <= 15'h2fff || (mem_addr >= 15'h3c00 && mem_addr <= 15'h3e27))
		else $error("memory request outside the data areas");
	a_lane_used: assert property (mem_req && mem_we |-> mem_wstrb != 2'b00)
		else $error("memory write without a byte lane");

	// ============================================================
	// Register port: one wait state, one-cycle answer.
	a_apb_wait: assert property (psel && penable && !pready |=> pready)
		else $error("register access not answered after one wait state");
	a_apb_single: assert property (pready |=> !pready)
		else $error("register answer longer than one cycle");
	a_err_ready: assert property (pslverr |-> pready)
		else $error("error flag outside an answer");
	a_rdata_idle: assert property (!pready |-> prdata == 32'h0)
		else $error("read data driven outside an answer");
endmodule

bind buffer_dma_copy_checksum dma_port_checker i_dma_port_checker (
	.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
	.mem_req, .mem_we, .mem_addr, .mem_wdata, .mem_wstrb, .mem_ack, .mem_rdata, .irq
);

/* File: bench/buffer_dma_copy_checksum_bench.sv */
// Self-checking bench of the buffer DMA engine against a word memory model.
`timescale 1ns/1ns
module buffer_dma_copy_checksum_bench;
	logic        pclk    = 1'b0;
	logic        presetn = 1'b0;
	logic        psel    = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite  = 1'b0;
	logic [7:0]  paddr   = 8'h00;
	logic [31:0] pwdata  = 32'h0;
	logic [3:0]  stall   = 4'h0;
	logic [31:0] prdata, r;
	logic        pready, pslverr, mem_req, mem_we, mem_ack, irq, e;
	logic [14:0] mem_addr;
	logic [15:0] mem_wdata, mem_rdata;
	logic [1:0]  mem_wstrb;
	int          n_fail = 0;
	int          checked = 0;
	int          cycles = 0;

	buffer_dma_copy_checksum i_buffer_dma_copy_checksum (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
		.pwdata, .prdata, .pready, .pslverr, .mem_req, .mem_we, .mem_addr, .mem_wdata, .mem_wstrb, .mem_ack,
		.mem_rdata, .irq);
	sram_partner i_sram_partner (.pclk, .presetn, .mem_req, .mem_we, .mem_addr, .mem_wdata, .mem_wstrb,
		.stall, .mem_ack, .mem_rdata);

	// ============================================================
	// Clock, and a ceiling well above the longest expected run.
	always #4 pclk = ~pclk;
	always @(posedge pclk) begin
		cycles <= cycles + 1;
		if (cycles == 40000) begin
			n_fail = n_fail + 1;
			wrap_up();
		end
	end

	task wrap_up;
		$display("checks %0d mismatches %0d", checked, n_fail);
		if (n_fail == 0 && checked > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask

	task chk(input string nm, input logic [31:0] s, input logic [31:0] x);
		checked++;
		if (s !== x) begin
			n_fail++;
			$display("BAD %s expected %h seen %h", nm, x, s);
		end
	endtask

	// ============================================================
	// APB master: request held until pready is sampled high, data taken at that edge.
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (n >= 20) chk("apb answer", 32'h0, 32'h1);
	endtask

	// Settings are written only while idle, then run is set and polled until hardware clears it.
	task run(input logic [3:0] ctl);
		int n;
		n = 0;
		apb(1'b1, 8'h00, {28'h0, ctl | 4'h1});
		do begin
			apb(1'b0, 8'h00, 32'h0);
			n++;
		end while (r[0] !== 1'b0 && n < 3000);
		chk("run cleared", r & 32'h1, 32'h0);
	endtask

	// Byte view of the word memory, even byte in the low lane.
	task load(input logic [15:0] a, input logic [31:0] v);
		for (int i = 0; i < 4; i++) begin
			if (a[0] ^ i[0]) i_sram_partner.ram[(a + i) >> 1][15:8] = v[31 - 8 * i -: 8];
			else i_sram_partner.ram[(a + i) >> 1][7:0] = v[31 - 8 * i -: 8];
		end
	endtask
	task cb(input logic [15:0] a, input logic [7:0] x);
		logic [15:0] w;
		w = i_sram_partner.ram[a >> 1];
		chk("memory byte", {24'h0, a[0] ? w[15:8] : w[7:0]}, {24'h0, x});
	endtask

	// ============================================================
	// Scenarios.
	task s_regs;
		apb(1'b0, 8'h14, 32'h0);
		chk("ua start", r, 32'h5ffe);
		apb(1'b0, 8'h1c, 32'h0);
		chk("rx start", r, 32'h5340);
		apb(1'b0, 8'h28, 32'h0);
		chk("unmapped err", {31'h0, e}, 32'h1);
	endtask

	task s_sum;
		load(16'h0101, 32'h89abcd00);
		load(16'h0000, 32'h00010000);
		apb(1'b1, 8'h20, 32'h3);
		apb(1'b1, 8'h04, 32'h0101);
		apb(1'b1, 8'h0c, 32'h3);
		run(4'h0);
		apb(1'b0, 8'h10, 32'h0);
		chk("odd sum", r, 32'ha953);
		apb(1'b0, 8'h24, 32'h0);
		chk("done", r & 32'h1, 32'h1);
		chk("irq on", {31'h0, irq}, 32'h1);
		apb(1'b1, 8'h20, 32'h1);
		repeat (2) @(posedge pclk);
		chk("irq gated", {31'h0, irq}, 32'h0);
		apb(1'b1, 8'h24, 32'h1);
		apb(1'b0, 8'h24, 32'h0);
		chk("done cleared", r & 32'h1, 32'h0);
		apb(1'b1, 8'h0c, 32'h0);
		run(4'h0);
		apb(1'b0, 8'h10, 32'h0);
		chk("zero length", r, 32'hffff);
		apb(1'b1, 8'h10, 32'hfffe);
		apb(1'b1, 8'h04, 32'h0);
		apb(1'b1, 8'h0c, 32'h2);
		stall <= 4'h3;
		run(4'h8);
		apb(1'b0, 8'h10, 32'h0);
		chk("seeded sum", r, 32'hfffd);
		run(4'h4);
		apb(1'b0, 8'h10, 32'h0);
		chk("inhibit only", r, 32'hfffd);
	endtask

	task s_copy;
		load(16'h0003, 32'h10111213);
		load(16'h0007, 32'h14000000);
		apb(1'b1, 8'h04, 32'h3);
		apb(1'b1, 8'h08, 32'h2);
		apb(1'b1, 8'h0c, 32'h5);
		run(4'h2);
		for (int i = 0; i < 5; i++) cb(16'h0002 + i[15:0], 8'h10 + i[7:0]);
		cb(16'h0007, 8'h14);
		apb(1'b0, 8'h10, 32'h0);
		chk("copy sum", r, 32'hc9db);
		apb(1'b1, 8'h04, 32'h2);
		apb(1'b1, 8'h08, 32'h7800);
		apb(1'b1, 8'h0c, 32'h4);
		run(4'h6);
		for (int i = 0; i < 4; i++) cb(16'h7800 + i[15:0], 8'h10 + i[7:0]);
		apb(1'b0, 8'h10, 32'h0);
		chk("sum kept", r, 32'hc9db);
	endtask

	task s_wrap;
		load(16'h533e, 32'ha0a15555);
		load(16'h0000, 32'ha2a30000);
		apb(1'b1, 8'h04, 32'h533e);
		apb(1'b1, 8'h08, 32'h5ffe);
		apb(1'b1, 8'h0c, 32'h4);
		run(4'h6);
		cb(16'h5ffe, 8'ha2);
		cb(16'h5fff, 8'ha3);
		cb(16'h5340, 8'h55);
		apb(1'b1, 8'h14, 32'h2000);
		apb(1'b1, 8'h18, 32'h2001);
		apb(1'b1, 8'h04, 32'h0);
		apb(1'b1, 8'h08, 32'h5fff);
		apb(1'b1, 8'h0c, 32'h2);
		run(4'h6);
		cb(16'h5340, 8'ha3);
	endtask

	task s_cancel;
		apb(1'b1, 8'h24, 32'h1);
		apb(1'b1, 8'h20, 32'h3);
		stall <= 4'h8;
		apb(1'b1, 8'h04, 32'h0);
		apb(1'b1, 8'h0c, 32'h1000);
		apb(1'b1, 8'h00, 32'h1);
		repeat (20) @(posedge pclk);
		apb(1'b0, 8'h24, 32'h0);
		chk("busy", r & 32'h3, 32'h2);
		apb(1'b1, 8'h00, 32'h0);
		repeat (12) @(posedge pclk);
		apb(1'b0, 8'h24, 32'h0);
		chk("cancelled", r & 32'h3, 32'h0);
		chk("no irq", {31'h0, irq}, 32'h0);
	endtask

	// ============================================================
	// Main sequence, ending in the one closing report.
	initial begin
		repeat (8) @(posedge pclk);
		// Leaving reset stands in for the enable and clock-ready checks before the first run.
		presetn <= 1'b1;
		s_regs;
		s_sum;
		s_copy;
		s_wrap;
		s_cancel;
		wrap_up;
	end
endmodule

/* File: bench/sram_partner.sv */
// Word memory model standing behind the engine's memory port.
`timescale 1ns/1ns
module sram_partner (
	input wire         pclk,
	input wire         presetn,
	input wire         mem_req,
	input wire         mem_we,
	input wire  [14:0] mem_addr,
	input wire  [15:0] mem_wdata,
	input wire  [1:0]  mem_wstrb,
	input wire  [3:0]  stall,
	output logic       mem_ack,
	output logic [15:0] mem_rdata
);
	logic [15:0] ram [0:32767];
	int          cnt;

	// ============================================================
	// Answer after stall cycles; read data toggles outside an answer so stale data is never trusted.
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mem_ack <= 1'b0;
			cnt <= 0;
			mem_rdata <= 16'h0000;
		end else begin
			mem_ack <= 1'b0;
			mem_rdata <= ~mem_rdata;
			if (mem_req && !mem_ack) begin
				if (cnt >= stall) begin
					mem_ack <= 1'b1;
					cnt <= 0;
					mem_rdata <= ram[mem_addr];
					if (mem_we && mem_wstrb[0]) ram[mem_addr][7:0] <= mem_wdata[7:0];
					if (mem_we && mem_wstrb[1]) ram[mem_addr][15:8] <= mem_wdata[15:8];
				end else begin
					cnt <= cnt + 1;
				end
			end else if (!mem_req) begin
				cnt <= 0;
			end
		end
	end
endmodule

/* File: core/buffer_dma_copy_checksum.v */
// Buffer DMA engine: byte copy and one's-complement checksum over word memory, with APB registers.
//
// Register access over APB and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ns
`include "dma_defines.vh"

module buffer_dma_copy_checksum (
	input  wire        pclk,
	input  wire        presetn,
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [7:0]  paddr,
	input  wire [31:0] pwdata,
	output reg  [31:0] prdata,
	output reg         pready,
	output reg         pslverr,
	output reg         mem_req,
	output reg         mem_we,
	output reg  [14:0] mem_addr,
	output reg  [15:0] mem_wdata,
	output reg  [1:0]  mem_wstrb,
	input  wire        mem_ack,
	input  wire [15:0] mem_rdata,
	output reg         irq
);

	// ============================================================
	// State encoding
	localparam [3:0] ST_IDLE  = 4'b0001;
	localparam [3:0] ST_READ  = 4'b0010;
	localparam [3:0] ST_WRITE = 4'b0100;
	localparam [3:0] ST_FIN   = 4'b1000;

	// ============================================================
	// Software-visible registers
	reg        dma_run_q;
	reg        copy_select_q;
	reg        checksum_inhibit_q;
	reg        checksum_seed_select_q;
	reg [15:0] source_pointer_q;
	reg [15:0] destination_pointer_q;
	reg [15:0] transfer_length_q;
	reg [15:0] checksum_result_q;
	reg [15:0] user_area_start_q;
	reg [15:0] user_area_end_q;
	reg [15:0] receive_buffer_start_q;
	reg        dma_done_irq_enable_q;
	reg        global_irq_enable_q;
	reg        done_flag_q;

	// ============================================================
	// Engine working state
	reg [3:0]  state_q;
	reg [15:0] src_q;
	reg [15:0] dst_q;
	reg [15:0] remain_q;
	reg [15:0] sum_q;
	reg        parity_q;
	reg [7:0]  byte_a_q;
	reg [7:0]  byte_b_q;
	reg [1:0]  pending_q;

	// ============================================================
	// Combinational helpers
	reg [31:0] rd_d;
	reg        rd_err_d;
	reg        take_two;
	reg        put_two;
	reg [7:0]  in_a;
	reg [7:0]  in_b;
	reg [15:0] src_data;
	reg [15:0] src_next1;
	reg [15:0] src_next2;
	reg [15:0] dst_next1;
	reg [15:0] dst_next2;
	reg [15:0] add_word;
	reg [16:0] raw_sum;
	reg [15:0] sum_d;

	wire apb_access = psel & penable;
	wire apb_commit = apb_access & pready;
	wire apb_wr     = apb_commit & pwrite;

	// Next byte address after a, checking the user area first, then the general buffer,
	// then the end of physical memory.
	function [15:0] wrap_next;
		input [15:0] a;
		begin
			if (a == user_area_end_q) begin
				wrap_next = user_area_start_q;
			end else if (a == receive_buffer_start_q - 16'h0001) begin
				wrap_next = 16'h0000;
			end else if (a == `SRAM_LAST) begin
				wrap_next = receive_buffer_start_q;
			end else begin
				wrap_next = a + 16'h0001;
			end
		end
	endfunction

	// True only for implemented SRAM and the crypto data area, so registers are never touched.
	function addr_ok;
		input [15:0] a;
		begin
			addr_ok = (a <= `SRAM_LAST) || ((a >= `CRYPTO_FIRST) && (a <= `CRYPTO_LAST));
		end
	endfunction

	// ============================================================
	// Byte selection, pointer advance and the one's-complement adder.
	// A word is taken whole only if both bytes really are consecutive after wrapping;
	// otherwise one byte per access keeps every wrap exact at the cost of speed.
	always @* begin
		src_next1 = wrap_next(src_q);
		src_next2 = wrap_next(src_next1);
		dst_next1 = wrap_next(dst_q);
		dst_next2 = wrap_next(dst_next1);
		take_two  = ~src_q[0] && (remain_q >= 16'h0002) && (src_next1 == src_q + 16'h0001);
		put_two   = (pending_q == 2'd2) && ~dst_q[0] && (dst_next1 == dst_q + 16'h0001);
		src_data  = addr_ok(src_q) ? mem_rdata : 16'h0000;
		in_a      = src_q[0] ? src_data[15:8] : src_data[7:0];
		in_b      = src_data[15:8];
		// Stream position, not address, decides which byte is the high half.
		if (take_two) begin
			add_word = parity_q ? {in_b, in_a} : {in_a, in_b};
		end else begin
			add_word = parity_q ? {8'h00, in_a} : {in_a, 8'h00};
		end
		raw_sum = {1'b0, sum_q} + {1'b0, add_word};
		sum_d   = raw_sum[15:0] + {15'h0000, raw_sum[16]};
	end

	// ============================================================
	// Register read decode.
	always @* begin
		rd_d     = 32'h0000_0000;
		rd_err_d = 1'b0;
		if (paddr == `OFS_CONTROL) begin
			rd_d[`BIT_RUN]     = dma_run_q;
			rd_d[`BIT_COPY]    = copy_select_q;
			rd_d[`BIT_NO_CSUM] = checksum_inhibit_q;
			rd_d[`BIT_SEED]    = checksum_seed_select_q;
		end else if (paddr == `OFS_SOURCE) begin
			rd_d[15:0] = source_pointer_q;
		end else if (paddr == `OFS_DEST) begin
			rd_d[15:0] = destination_pointer_q;
		end else if (paddr == `OFS_LENGTH) begin
			rd_d[15:0] = transfer_length_q;
		end else if (paddr == `OFS_CHECKSUM) begin
			rd_d[15:0] = checksum_result_q;
		end else if (paddr == `OFS_UA_START) begin
			rd_d[15:0] = user_area_start_q;
		end else if (paddr == `OFS_UA_END) begin
			rd_d[15:0] = user_area_end_q;
		end else if (paddr == `OFS_RX_START) begin
			rd_d[15:0] = receive_buffer_start_q;
		end else if (paddr == `OFS_IRQ_ENABLE) begin
			rd_d[`BIT_DONE_IE]   = dma_done_irq_enable_q;
			rd_d[`BIT_GLOBAL_IE] = global_irq_enable_q;
		end else if (paddr == `OFS_STATUS) begin
			rd_d[`BIT_DONE] = done_flag_q;
			rd_d[`BIT_BUSY] = ~state_q[0];
		end else begin
			rd_err_d = 1'b1;
		end
	end

	// ============================================================
	// APB slave: one wait state, so the answer comes from flops on the second access cycle.
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready  <= 1'b0;
			prdata  <= 32'h0000_0000;
			pslverr <= 1'b0;
		end else if (apb_access && !pready) begin
			pready  <= 1'b1;
			prdata  <= pwrite ? 32'h0000_0000 : rd_d;
			pslverr <= rd_err_d;
		end else begin
			pready  <= 1'b0;
			prdata  <= 32'h0000_0000;
			pslverr <= 1'b0;
		end
	end

	// ============================================================
	// Interrupt output, registered so it comes straight from a flop.
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq <= 1'b0;
		end else begin
			irq <= done_flag_q & dma_done_irq_enable_q & global_irq_enable_q;
		end
	end

	// ============================================================
	// Configuration registers. Pointers are copied into working registers at start, so a
	// careless write while running cannot move the live pointers; the wrap bounds stay live.
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			source_pointer_q       <= 16'h0000;
			destination_pointer_q  <= 16'h0000;
			transfer_length_q      <= 16'h0000;
			user_area_start_q      <= `RST_UA_START;
			user_area_end_q        <= `RST_UA_END;
			receive_buffer_start_q <= `RST_RX_START;
			dma_done_irq_enable_q  <= 1'b0;
			global_irq_enable_q    <= 1'b0;
			copy_select_q          <= 1'b0;
			checksum_inhibit_q     <= 1'b0;
			checksum_seed_select_q <= 1'b0;
		end else if (apb_wr && !pslverr) begin
			if (paddr == `OFS_CONTROL) begin
				copy_select_q          <= pwdata[`BIT_COPY];
				checksum_inhibit_q     <= pwdata[`BIT_NO_CSUM];
				checksum_seed_select_q <= pwdata[`BIT_SEED];
			end else if (paddr == `OFS_SOURCE) begin
				source_pointer_q <= pwdata[15:0];
			end else if (paddr == `OFS_DEST) begin
				destination_pointer_q <= pwdata[15:0];
			end else if (paddr == `OFS_LENGTH) begin
				transfer_length_q <= pwdata[15:0];
			end else if (paddr == `OFS_UA_START) begin
				user_area_start_q <= pwdata[15:0];
			end else if (paddr == `OFS_UA_END) begin
				user_area_end_q <= pwdata[15:0];
			end else if (paddr == `OFS_RX_START) begin
				receive_buffer_start_q <= pwdata[15:0];
			end else if (paddr == `OFS_IRQ_ENABLE) begin
				dma_done_irq_enable_q <= pwdata[`BIT_DONE_IE];
				global_irq_enable_q   <= pwdata[`BIT_GLOBAL_IE];
			end
		end
	end

	// ============================================================
	// Engine, run bit, done flag and checksum result. Software and hardware both touch the
	// run bit, the done flag and the checksum, so they live here with the engine.
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_q           <= ST_IDLE;
			dma_run_q         <= 1'b0;
			done_flag_q       <= 1'b0;
			checksum_result_q <= 16'h0000;
			src_q             <= 16'h0000;
			dst_q             <= 16'h0000;
			remain_q          <= 16'h0000;
			sum_q             <= 16'h0000;
			parity_q          <= 1'b0;
			byte_a_q          <= 8'h00;
			byte_b_q          <= 8'h00;
			pending_q         <= 2'd0;
			mem_req           <= 1'b0;
			mem_we            <= 1'b0;
			mem_addr          <= 15'h0000;
			mem_wdata         <= 16'h0000;
			mem_wstrb         <= 2'b00;
		end else begin
			// Software writes first; the hardware events below override where they collide.
			if (apb_wr && (paddr == `OFS_CONTROL)) begin
				dma_run_q <= pwdata[`BIT_RUN];
			end
			if (apb_wr && (paddr == `OFS_CHECKSUM)) begin
				checksum_result_q <= pwdata[15:0];
			end
			if (apb_wr && (paddr == `OFS_STATUS) && pwdata[`BIT_DONE]) begin
				done_flag_q <= 1'b0;
			end
			case (state_q)
				ST_IDLE: begin
					mem_req <= 1'b0;
					if (dma_run_q) begin
						src_q     <= source_pointer_q;
						dst_q     <= destination_pointer_q;
						remain_q  <= transfer_length_q;
						sum_q     <= checksum_seed_select_q ? ~checksum_result_q : 16'h0000;
						parity_q  <= 1'b0;
						pending_q <= 2'd0;
						state_q   <= ST_READ;
					end
				end
				ST_READ: begin
					if (!dma_run_q) begin
						mem_req <= 1'b0;
						state_q <= ST_IDLE;
					end else if (remain_q == 16'h0000) begin
						state_q <= ST_FIN;
					end else if (addr_ok(src_q) && !mem_req) begin
						mem_req  <= 1'b1;
						mem_we   <= 1'b0;
						mem_addr <= src_q[15:1];
					end else if (!addr_ok(src_q) || mem_ack) begin
						// One or two bytes consumed, in ascending stream order.
						mem_req  <= 1'b0;
						sum_q    <= sum_d;
						parity_q <= take_two ? parity_q : ~parity_q;
						byte_a_q <= in_a;
						byte_b_q <= in_b;
						if (take_two) begin
							src_q     <= src_next2;
							remain_q  <= remain_q - 16'h0002;
							pending_q <= 2'd2;
						end else begin
							src_q     <= src_next1;
							remain_q  <= remain_q - 16'h0001;
							pending_q <= 2'd1;
						end
						if (copy_select_q) begin
							state_q <= ST_WRITE;
						end
					end
				end
				ST_WRITE: begin
					if (!dma_run_q) begin
						mem_req <= 1'b0;
						state_q <= ST_IDLE;
					end else if (pending_q == 2'd0) begin
						state_q <= ST_READ;
					end else if (addr_ok(dst_q) && !mem_req) begin
						// Even data byte sits in the low lane, odd in the high lane.
						mem_req  <= 1'b1;
						mem_we   <= 1'b1;
						mem_addr <= dst_q[15:1];
						if (put_two) begin
							mem_wdata <= {byte_b_q, byte_a_q};
							mem_wstrb <= 2'b11;
						end else begin
							mem_wdata <= {byte_a_q, byte_a_q};
							mem_wstrb <= dst_q[0] ? 2'b10 : 2'b01;
						end
					end else if (!addr_ok(dst_q) || mem_ack) begin
						// The pad byte never reaches here: only real bytes are pending.
						mem_req <= 1'b0;
						mem_we  <= 1'b0;
						if (put_two) begin
							dst_q     <= dst_next2;
							pending_q <= 2'd0;
						end else begin
							dst_q     <= dst_next1;
							byte_a_q  <= byte_b_q;
							pending_q <= pending_q - 2'd1;
						end
					end
				end
				ST_FIN: begin
					// Completion wins over a coincident software clear of the flag.
					if (!checksum_inhibit_q) begin
						checksum_result_q <= ~sum_q;
					end
					dma_run_q   <= 1'b0;
					done_flag_q <= 1'b1;
					state_q     <= ST_IDLE;
				end
				default: begin
					state_q <= ST_IDLE;
				end
			endcase
		end
	end

endmodule

/* File: core/dma_defines.vh */
// Register map, field positions, reset values and memory bounds of the buffer DMA engine.
`ifndef DMA_DEFINES_VH
`define DMA_DEFINES_VH

// ============================================================
// Register byte offsets
`define OFS_CONTROL     8'h00
`define OFS_SOURCE      8'h04
`define OFS_DEST        8'h08
`define OFS_LENGTH      8'h0c
`define OFS_CHECKSUM    8'h10
`define OFS_UA_START    8'h14
`define OFS_UA_END      8'h18
`define OFS_RX_START    8'h1c
`define OFS_IRQ_ENABLE  8'h20
`define OFS_STATUS      8'h24

// ============================================================
// Field positions
`define BIT_RUN         0
`define BIT_COPY        1
`define BIT_NO_CSUM     2
`define BIT_SEED        3
`define BIT_DONE_IE     0
`define BIT_GLOBAL_IE   1
`define BIT_DONE        0
`define BIT_BUSY        1

// ============================================================
// Reset values
`define RST_UA_START    16'h5ffe
`define RST_UA_END      16'h5fff
`define RST_RX_START    16'h5340

// ============================================================
// Memory layout
`define SRAM_LAST       16'h5fff
`define CRYPTO_FIRST    16'h7800
`define CRYPTO_LAST     16'h7c4f

`endif
